// ==== rtl/dph_host.sv ====
// Host controller that drives one port of an asynchronous dual-port RAM.
// Assumes the RAM port pins are wired directly; busy and data come back unsynchronised.
`timescale 1ns/1ns
`default_nettype none
`include "dph_regs.svh"

module dph_host (
  input  wire logic                   sys_clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   cmd_valid_i,
  output logic                        cmd_ready_o,
  input  wire dph_pkg::dph_cmd_t      cmd_i,
  output logic                        rsp_valid_o,
  output logic [`DPH_DATA_W-1:0]      rsp_data_o,
  output logic                        rsp_token_held_o,
  output dph_pkg::dph_pins_t          pins_o,
  input  wire logic [`DPH_DATA_W-1:0] data_i,
  input  wire logic                   busy_n_i
);

  localparam logic [3:0] ACT_CYC = 4'(`DPH_ACT_CYC);
  localparam logic [3:0] REC_CYC = 4'(`DPH_REC_CYC);

  dph_pkg::dph_state_t st;
  dph_pkg::dph_cmd_t   cur;
  logic [3:0]          cnt;
  logic                readback;
  logic [`DPH_DATA_W-1:0] data_s;
  logic                busy_n_s;

  dph_sync #(.W(`DPH_DATA_W), .RST_VAL('0)) u_data_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (data_i),
    .sync_o    (data_s)
  );

  dph_sync #(.W(1), .RST_VAL(1'b1)) u_busy_sync (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (busy_n_i),
    .sync_o    (busy_n_s)
  );

  // Decoding of the latched command.
  wire is_token  = (cur.kind != dph_pkg::DPH_MEM_READ) && (cur.kind != dph_pkg::DPH_MEM_WRITE);
  wire claim_wr  = (cur.kind == dph_pkg::DPH_TOKEN_CLAIM) && !readback;
  wire is_write  = (cur.kind == dph_pkg::DPH_MEM_WRITE) ||
                   (cur.kind == dph_pkg::DPH_TOKEN_RELEASE) || claim_wr;
  wire tok_value = (cur.kind == dph_pkg::DPH_TOKEN_RELEASE);
  wire cnt_done  = (cnt == 4'h0);
  wire busy_hit  = !is_token && !busy_n_s;
  wire take_cmd  = cmd_valid_i && cmd_ready_o;
  wire capture   = (st == dph_pkg::DPH_ACTIVE) && cnt_done && !is_write && !busy_hit;
  wire last_ph   = !claim_wr;
  wire [`DPH_DATA_W-1:0] wr_data = is_token ?
                   {{(`DPH_DATA_W-1){1'b0}}, tok_value} : cur.data; // R7 R14

  assign cmd_ready_o = (st == dph_pkg::DPH_IDLE);

  dph_pkg::dph_state_t next_st;
  always_comb begin
    next_st = st;
    case (st)
      dph_pkg::DPH_IDLE:    if (cmd_valid_i) next_st = dph_pkg::DPH_SETUP;
      dph_pkg::DPH_SETUP:   next_st = dph_pkg::DPH_ACTIVE;
      dph_pkg::DPH_ACTIVE: begin
        if (busy_hit) next_st = dph_pkg::DPH_BUSY; // R11 R12 R13
        else if (cnt_done) next_st = dph_pkg::DPH_RECOVER;
      end
      dph_pkg::DPH_BUSY:    if (busy_n_s) next_st = dph_pkg::DPH_SETUP;
      dph_pkg::DPH_RECOVER: begin
        if (cnt_done) next_st = last_ph ? dph_pkg::DPH_DONE : dph_pkg::DPH_SETUP;
      end
      dph_pkg::DPH_DONE:    next_st = dph_pkg::DPH_IDLE;
      default:              next_st = dph_pkg::DPH_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st  <= dph_pkg::DPH_IDLE;
      cur <= '0;
      cnt <= 4'h0;
    end else begin
      st <= next_st;
      if (take_cmd) cur <= cmd_i;
      if (next_st == dph_pkg::DPH_ACTIVE && st != dph_pkg::DPH_ACTIVE) cnt <= ACT_CYC - 4'h1;
      else if (next_st == dph_pkg::DPH_RECOVER && st != dph_pkg::DPH_RECOVER) cnt <= REC_CYC - 4'h1;
      else if (!cnt_done) cnt <= cnt - 4'h1;
    end
  end

  // A claim is a token write followed by a read-back of the same token.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) readback <= 1'b0;
    else if (take_cmd) readback <= 1'b0;
    else if (st == dph_pkg::DPH_RECOVER && cnt_done && claim_wr) readback <= 1'b1; // R10
  end

  // Pin drive. Select and read/write fall together, so the RAM never drives into our write data.
  dph_pkg::dph_pins_t next_pins;
  always_comb begin
    next_pins                     = pins_o;
    next_pins.port_select_n       = 1'b1;
    next_pins.token_select_n      = 1'b1;
    next_pins.read_write          = 1'b1;
    next_pins.output_enable_n     = 1'b1;
    next_pins.upper_lane_enable_n = 1'b1;
    next_pins.lower_lane_enable_n = 1'b1;
    next_pins.data_oe             = 1'b0;
    if (take_cmd) next_pins.addr = cmd_i.addr; // R5
    if (next_st == dph_pkg::DPH_ACTIVE || next_st == dph_pkg::DPH_BUSY) begin
      if (is_token) begin
        next_pins.token_select_n      = 1'b0; // R2 R3 R10
        next_pins.lower_lane_enable_n = 1'b0; // R4
      end else begin
        next_pins.port_select_n       = 1'b0; // R2
        next_pins.upper_lane_enable_n = !cur.upper_lane;
        next_pins.lower_lane_enable_n = !cur.lower_lane;
      end
    end
    if (next_st == dph_pkg::DPH_ACTIVE) begin
      next_pins.read_write      = !is_write; // R1 R4 R6
      next_pins.output_enable_n = is_write;
      next_pins.data_oe         = is_write;
      next_pins.data            = wr_data;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pins_o <= '{addr: '0, data: '0, data_oe: 1'b0, read_write: 1'b1, default: 1'b1};
    end else begin
      pins_o <= next_pins;
    end
  end

  // Answer. A token bit read as zero means this port owns it; a token is free after reset.
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rsp_valid_o      <= 1'b0;
      rsp_data_o       <= '0;
      rsp_token_held_o <= 1'b0; // R9
    end else begin
      rsp_valid_o <= (next_st == dph_pkg::DPH_DONE);
      if (capture) begin
        rsp_data_o       <= data_s;
        rsp_token_held_o <= is_token && !data_s[`DPH_TOKEN_BIT]; // R8 R15
      end
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  AST_READ_RW_HIGH: assert property ( // R1
    st == dph_pkg::DPH_ACTIVE && !is_write |-> pins_o.read_write && !pins_o.data_oe)
    else $error("Read cycle with read/write low.");
  AST_ONE_SELECT: assert property ( // R2
    !(!pins_o.port_select_n && !pins_o.token_select_n))
    else $error("Port select and token select low together.");
  AST_MEM_LANE: assert property ( // R2
    !pins_o.port_select_n && !pins_o.read_write |->
      !(pins_o.upper_lane_enable_n && pins_o.lower_lane_enable_n))
    else $error("Memory write with no byte lane.");
  AST_TOKEN_CAPTURE: assert property ( // R3
    capture && is_token |-> !pins_o.token_select_n && !pins_o.output_enable_n)
    else $error("Token state sampled without token select.");
  AST_ADDR_RW: assert property ( // R5
    !$stable(pins_o.addr) |-> pins_o.read_write && $past(pins_o.read_write))
    else $error("Address moved while read/write low.");
  AST_CLAIM_ZERO: assert property ( // R7
    !pins_o.read_write && !pins_o.token_select_n && cur.kind == dph_pkg::DPH_TOKEN_CLAIM
      |-> pins_o.data_oe && !pins_o.data[`DPH_TOKEN_BIT])
    else $error("Claim did not drive zero on the request bit.");
  AST_RELEASE_ONE: assert property ( // R14
    !pins_o.read_write && !pins_o.token_select_n && cur.kind == dph_pkg::DPH_TOKEN_RELEASE
      |-> pins_o.data_oe && pins_o.data[`DPH_TOKEN_BIT])
    else $error("Release did not drive one on the request bit.");
  AST_CLAIM_READBACK: assert property ( // R10
    $rose(pins_o.token_select_n) && cur.kind == dph_pkg::DPH_TOKEN_CLAIM && !readback
      |-> pins_o.port_select_n [*3] ##1 !pins_o.token_select_n && pins_o.read_write)
    else $error("Claim read-back did not follow with port select high.");
  AST_BUSY_BACKOFF: assert property ( // R13
    st == dph_pkg::DPH_ACTIVE && busy_hit |=> pins_o.read_write && !pins_o.data_oe
      && !pins_o.port_select_n)
    else $error("Write not withdrawn after busy.");

  AST_WRITE_OUTPUTS_OFF: assert property ( // R6
    !pins_o.read_write |-> pins_o.output_enable_n && pins_o.data_oe)
    else $error("Write cycle with RAM outputs enabled.");

  AST_WRITE_QUALIFIED: assert property ( // R4
    !pins_o.read_write |-> (!pins_o.port_select_n || !pins_o.token_select_n)
      && !(pins_o.upper_lane_enable_n && pins_o.lower_lane_enable_n))
    else $error("Write strobe without a select and a byte lane.");

  // A select that falls before read/write would let the RAM drive into our write data.
  AST_SELECT_WITH_WRITE: assert property ( // R6
    $fell(pins_o.read_write) |->
      $fell(pins_o.port_select_n) || $fell(pins_o.token_select_n))
    else $error("Read/write fell apart from the select.");

  AST_TOKEN_NO_PORT: assert property ( // R10
    !pins_o.token_select_n |-> pins_o.port_select_n && !pins_o.lower_lane_enable_n)
    else $error("Token access with port select low.");

  AST_BUSY_PARKED: assert property ( // R11
    st == dph_pkg::DPH_BUSY |->
      pins_o.read_write && !pins_o.data_oe && pins_o.output_enable_n)
    else $error("Port not parked while busy.");

  AST_RSP_PULSE: assert property ( // R15
    rsp_valid_o |=> !rsp_valid_o)
    else $error("Completion pulse longer than one cycle.");

  COV_MEM_WRITE: cover property (take_cmd && cmd_i.kind == dph_pkg::DPH_MEM_WRITE);
  COV_BUSY_WAIT: cover property (st == dph_pkg::DPH_BUSY ##1 st == dph_pkg::DPH_SETUP);
  COV_CLAIM_WON: cover property (rsp_valid_o && rsp_token_held_o);
  COV_MEM_READ: cover property (capture && cur.kind == dph_pkg::DPH_MEM_READ);
  COV_TOKEN_RELEASE: cover property (take_cmd && cmd_i.kind == dph_pkg::DPH_TOKEN_RELEASE);

endmodule

`default_nettype wire

// ==== include/dph_regs.svh ====
// Timing counts, widths and field positions for the dual-port RAM port host.
// Assumes a 50 MHz system clock and the slowest speed grade of the RAM.
// Summary of operation
// R1 - Reads keep read/write high throughout.
// R2 - Memory: port select, lane low; token: token select.
// R3 - Token reads use token select, not address sequencing.
// R4 - Write needs select, lane and read/write low.
// R5 - Read/write high whenever address lines change.
// R6 - Select with write low keeps RAM outputs floating.
// R7 - Claim token by writing zero on request bit.
// R8 - Simultaneous claims grant the token to one port.
// R9 - Token is free after reset.
// R10 - Port select high across token write and read-back.
// R11 - Earlier port wins location; other sees busy.
// R12 - Busy follows address match, releases on mismatch.
// R13 - Busy on select onto held location, released after.
// R14 - Release token by writing one on request bit.
// R15 - Token read returns ownership seen by this port.
`ifndef DPH_REGS_SVH
`define DPH_REGS_SVH

`define DPH_ADDR_W        13
`define DPH_DATA_W        16
`define DPH_TOKEN_BIT     0
`define DPH_CLK_NS        20
`define DPH_T_AA_NS       55
`define DPH_T_SOP_NS      20
`define DPH_T_PS_NS       5
`define DPH_SYNC_CYC      2
`define DPH_ACC_CYC       ((`DPH_T_AA_NS + `DPH_CLK_NS - 1) / `DPH_CLK_NS)
`define DPH_ACT_CYC       (`DPH_ACC_CYC + `DPH_SYNC_CYC)
`define DPH_REC_CYC       ((`DPH_T_SOP_NS + `DPH_CLK_NS - 1) / `DPH_CLK_NS)

`endif

// ==== include/dph_pkg.sv ====
// Types shared by the dual-port RAM port host.
// Assumes dph_regs.svh is on the include path.
`include "dph_regs.svh"

package dph_pkg;

  typedef enum logic [2:0] {
    DPH_MEM_READ      = 3'h0,
    DPH_MEM_WRITE     = 3'h1,
    DPH_TOKEN_CLAIM   = 3'h2,
    DPH_TOKEN_RELEASE = 3'h3,
    DPH_TOKEN_READ    = 3'h4
  } dph_kind_t;

  typedef enum logic [2:0] {
    DPH_IDLE    = 3'h0,
    DPH_SETUP   = 3'h1,
    DPH_ACTIVE  = 3'h2,
    DPH_BUSY    = 3'h3,
    DPH_RECOVER = 3'h4,
    DPH_DONE    = 3'h5
  } dph_state_t;

  typedef struct packed {
    dph_kind_t               kind;
    logic [`DPH_ADDR_W-1:0]  addr;
    logic [`DPH_DATA_W-1:0]  data;
    logic                    upper_lane;
    logic                    lower_lane;
  } dph_cmd_t;

  typedef struct packed {
    logic [`DPH_ADDR_W-1:0]  addr;
    logic                    port_select_n;
    logic                    token_select_n;
    logic                    read_write;
    logic                    output_enable_n;
    logic                    upper_lane_enable_n;
    logic                    lower_lane_enable_n;
    logic [`DPH_DATA_W-1:0]  data;
    logic                    data_oe;
  } dph_pins_t;

endpackage

// ==== rtl/dph_sync.sv ====
// Two-flop synchroniser for pins that arrive without relation to sys_clk_i.
// Assumes each bit is independent; multi-bit values are sampled only once stable.
`timescale 1ns/1ns
`default_nettype none

module dph_sync #(
  parameter int          W        = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         sys_clk_i,
  input  wire logic         reset_n_i,
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta   <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end

endmodule

`default_nettype wire

// ==== tb/dph_ram_model.sv ====
// Behavioural model of one port of the dual-port RAM, with the far port scripted.
// Assumes the host drives the pin struct and the bench plays the other port.
`timescale 1ns/1ns
`default_nettype none
`include "dph_regs.svh"
module dph_ram_model #(
  parameter int PRIO_NS = 5
) (
  input  wire dph_pkg::dph_pins_t     pins_i,
  input  wire logic                   other_sel_n_i,
  input  wire logic [`DPH_ADDR_W-1:0] other_addr_i,
  input  wire logic                   other_own_i,
  output logic      [`DPH_DATA_W-1:0] data_o,
  output logic                        busy_n_o
);
  logic [15:0] mem [0:(1<<`DPH_ADDR_W)-1];
  logic [7:0]  ours = 8'h00;
  logic [15:0] val;
  logic [15:0] last;
  time         t_ours;
  time         t_oth;
  wire lane    = !(pins_i.upper_lane_enable_n && pins_i.lower_lane_enable_n);
  wire mem_sel = !pins_i.port_select_n && pins_i.token_select_n && lane;
  wire tok_sel = pins_i.port_select_n && !pins_i.token_select_n;
  wire wr      = !pins_i.read_write && lane && (mem_sel || tok_sel);
  wire drv     = pins_i.read_write && !pins_i.output_enable_n && (mem_sel || tok_sel);
  wire [2:0] ti = pins_i.addr[2:0];
  wire hit     = mem_sel && !other_sel_n_i && other_addr_i == pins_i.addr
                 && t_oth + PRIO_NS <= t_ours;
  // A blocked port must not corrupt memory, so a write is dropped while the other port holds it.
  always @* begin
    if (wr && mem_sel && !hit) begin
      if (!pins_i.upper_lane_enable_n) mem[pins_i.addr][15:8] = pins_i.data[15:8];
      if (!pins_i.lower_lane_enable_n) mem[pins_i.addr][7:0] = pins_i.data[7:0];
    end
    if (wr && tok_sel) ours[ti] = pins_i.data[0] ? 1'b0 : !other_own_i;
    val = mem_sel ? mem[pins_i.addr] : {15'h7fff, !ours[ti]};
    if (drv) last = val;
  end
  // Released data lines show the inverse of the last value, never a stale match.
  assign #20 data_o = drv ? val : ~last;
  always @(negedge pins_i.port_select_n) t_ours = $time;
  always @(negedge other_sel_n_i) t_oth = $time;
  assign #15 busy_n_o = !hit;
endmodule
`default_nettype wire

// ==== tb/dual_port_sram_semaphore_busy_tb.sv ====
// Self-checking bench for the dual-port RAM port host.
// Assumes dph_ram_model stands in for the RAM and the bench plays the other port.
`timescale 1ns/1ns
`default_nettype none
`include "dph_regs.svh"
module dual_port_sram_semaphore_busy_tb;
  logic               sys_clk_i;
  logic               reset_n_i;
  logic               cmd_valid_i;
  dph_pkg::dph_cmd_t  cmd_i;
  logic               cmd_ready;
  logic               rsp_valid;
  logic [15:0]        rsp_data;
  logic               held;
  dph_pkg::dph_pins_t pins;
  logic [15:0]        data;
  logic               busy_n;
  logic               oth_sel_n;
  logic [12:0]        oth_addr;
  logic               oth_own;
  logic [12:0]        pa;
  int                 bad_count = 0;
  int                 checked = 0;
  int                 n;
  dph_host dph_host_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_ready_o(cmd_ready), .cmd_i(cmd_i),
    .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data), .rsp_token_held_o(held),
    .pins_o(pins), .data_i(data), .busy_n_i(busy_n));
  dph_ram_model dph_ram_model_inst (.pins_i(pins), .other_sel_n_i(oth_sel_n),
    .other_addr_i(oth_addr), .other_own_i(oth_own), .data_o(data), .busy_n_o(busy_n));
  always #10 sys_clk_i = ~sys_clk_i;
  task automatic tick();
    @(posedge sys_clk_i);
    #1;
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Issues one command and waits for its completion pulse, counting cycles.
  task automatic run(input dph_pkg::dph_kind_t k, input logic [12:0] a,
                     input logic [15:0] d, input logic [1:0] ln, output int c);
    c = 0;
    while (cmd_ready !== 1'b1) tick();
    cmd_i = '{kind: k, addr: a, data: d, upper_lane: ln[1], lower_lane: ln[0]};
    cmd_valid_i = 1'b1;
    tick();
    cmd_valid_i = 1'b0;
    cmp1(cmd_ready, 1'b0);
    while (rsp_valid !== 1'b1 && c < 2000) begin
      tick();
      c++;
    end
    if (c >= 2000) cmp1(1'b0, 1'b1);
  endtask
  task automatic t_mem();
    run(dph_pkg::DPH_MEM_WRITE, 13'h1fff, 16'hbeef, 2'b11, n);
    cmp16(16'(n), 16'(`DPH_ACT_CYC + `DPH_REC_CYC + 1));
    run(dph_pkg::DPH_MEM_WRITE, 13'h1fff, 16'h1234, 2'b10, n);
    run(dph_pkg::DPH_MEM_READ, 13'h1fff, 16'h0000, 2'b11, n);
    cmp16(16'(n), 16'(`DPH_ACT_CYC + `DPH_REC_CYC + 1));
    cmp16(rsp_data, 16'h12ef);
    $display("test mem done");
  endtask
  task automatic t_token();
    run(dph_pkg::DPH_TOKEN_CLAIM, 13'h0003, 16'h0000, 2'b00, n);
    cmp1(held, 1'b1);
    cmp16(16'(n), 16'(2 * (`DPH_ACT_CYC + `DPH_REC_CYC + 1)));
    run(dph_pkg::DPH_TOKEN_READ, 13'h0003, 16'h0000, 2'b00, n);
    cmp16(rsp_data, 16'hfffe);
    run(dph_pkg::DPH_TOKEN_RELEASE, 13'h0003, 16'h0000, 2'b00, n);
    run(dph_pkg::DPH_TOKEN_READ, 13'h0003, 16'h0000, 2'b00, n);
    cmp1(held, 1'b0);
    oth_own = 1'b1;
    run(dph_pkg::DPH_TOKEN_CLAIM, 13'h0005, 16'h0000, 2'b00, n);
    cmp1(held, 1'b0);
    oth_own = 1'b0;
    $display("test token done");
  endtask
  // The other port holds the location first, so this port must wait for it.
  task automatic t_busy();
    oth_addr = 13'h00a5;
    oth_sel_n = 1'b0;
    fork
      #800 oth_sel_n = 1'b1;
    join_none
    run(dph_pkg::DPH_MEM_WRITE, 13'h00a5, 16'h5a5a, 2'b11, n);
    cmp1(n > 40, 1'b1);
    run(dph_pkg::DPH_MEM_READ, 13'h00a5, 16'h0000, 2'b11, n);
    cmp16(rsp_data, 16'h5a5a);
    $display("test busy done");
  endtask
  always @(negedge sys_clk_i) begin
    if (reset_n_i === 1'b1) begin
      if (pins.token_select_n === 1'b0) cmp1(pins.port_select_n, 1'b1);
      if (pins.addr !== pa) cmp1(pins.read_write, 1'b1);
    end
    pa = pins.addr;
  end
  initial begin
    #100000;
    bad_count++;
    end_of_test();
  end
  initial begin
    sys_clk_i = 1'b0;
    reset_n_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_i = '0;
    oth_sel_n = 1'b1;
    oth_addr = 13'h0000;
    oth_own = 1'b0;
    repeat (8) @(posedge sys_clk_i);
    #1;
    cmp1(pins.port_select_n, 1'b1);
    cmp1(pins.read_write, 1'b1);
    cmp1(pins.data_oe, 1'b0);
    $display("test reset done");
    reset_n_i = 1'b1;
    t_mem();
    t_token();
    t_busy();
    end_of_test();
  end
endmodule
`default_nettype wire
